// [sbm_map.vh]
// Address map, access matrix and reset values of the six-layer bus matrix
`ifndef SBM_MAP_VH
`define SBM_MAP_VH
`define SBM_AW 32
`define SBM_DW 32
`define SBM_IW 3
`define SBM_SLOT_W 8
`define SBM_BANK_HI 31
`define SBM_BANK_LO 28
`define SBM_SUB_HI 27
`define SBM_SUB_LO 20
`define SBM_BANK_INT 4'h0
`define SBM_BANK_EXT_FIRST 4'h1
`define SBM_BANK_EXT_LAST 4'h7
`define SBM_BANK_PERIPH 4'hF
`define SBM_SUB_BOOT 8'h00
`define SBM_SUB_ROM 8'h01
`define SBM_SUB_SRAM0 8'h02
`define SBM_SUB_SRAM1 8'h03
`define SBM_SUB_USBH 8'h05
`define SBM_T_NONE 5'h00
`define SBM_T_SRAM0 5'h01
`define SBM_T_SRAM1 5'h02
`define SBM_T_ROMUSB 5'h04
`define SBM_T_EXT 5'h08
`define SBM_T_PERIPH 5'h10
`define SBM_ACC_CPU 5'h1F
`define SBM_ACC_DMA 5'h0B
`define SBM_FULL_MASTERS 3
`define SBM_ARB_FIXED 2'h0
`define SBM_ARB_RR_NONE 2'h1
`define SBM_ARB_RR_LAST 2'h2
`define SBM_ARB_RR_FIXED 2'h3
`define SBM_VSEL_3V3 1'b0
`define SBM_VSEL_1V8 1'b1
`define SBM_SLEW_FAST 1'b0
`define SBM_SLEW_SLOW 1'b1
`define SBM_BOOT_EXT 1'b0
`define SBM_BOOT_ROM 1'b1
`endif

// [sbm_decoder.v]
// Per-master address decoder with boot, remap and access filtering
`timescale 1ns/10ps
`include "sbm_map.vh"
module sbm_decoder
#(
    parameter [4:0] ACCESS = `SBM_ACC_CPU
)
(
    input wire [`SBM_AW-1:0] addr,
    input wire remap,
    input wire boot_select,
    output reg [4:0] target,
    output reg err
);
    reg [4:0] hit;
    wire [3:0] bank = addr[`SBM_BANK_HI:`SBM_BANK_LO];
    wire [7:0] sub = addr[`SBM_SUB_HI:`SBM_SUB_LO];

    always @*
    begin
        hit = `SBM_T_NONE;
        if (bank == `SBM_BANK_INT)
        begin
            case (sub)
                `SBM_SUB_BOOT:
                    if (remap)
                        hit = `SBM_T_SRAM0;
                    else if (boot_select == `SBM_BOOT_ROM)
                        hit = `SBM_T_ROMUSB;
                    else
                        hit = `SBM_T_EXT;
                `SBM_SUB_ROM: hit = `SBM_T_ROMUSB;
                `SBM_SUB_SRAM0: hit = `SBM_T_SRAM0;
                `SBM_SUB_SRAM1: hit = `SBM_T_SRAM1;
                `SBM_SUB_USBH: hit = `SBM_T_ROMUSB;
                default: hit = `SBM_T_NONE;
            endcase
        end
        else if (bank >= `SBM_BANK_EXT_FIRST && bank <= `SBM_BANK_EXT_LAST)
            hit = `SBM_T_EXT;
        else if (bank == `SBM_BANK_PERIPH)
            hit = `SBM_T_PERIPH;
        // Unmapped regions abort; unwired paths are never forwarded
        target = hit & ACCESS;
        err = (target == `SBM_T_NONE);
    end
endmodule // sbm_decoder

// [sbm_arbiter.v]
// Per-slave arbiter: fixed priority or round robin with slot-beat limit
`timescale 1ns/10ps
`include "sbm_map.vh"
module sbm_arbiter
#(
    parameter NM = 6
)
(
    input wire mclk,
    input wire reset_n,
    input wire ce,
    input wire [1:0] mode,
    input wire [`SBM_IW-1:0] default_master,
    input wire [`SBM_SLOT_W-1:0] slot_limit,
    input wire [NM-1:0] req,
    input wire [NM-1:0] burst_more,
    input wire beat_done,
    output reg [NM-1:0] gnt,
    output reg [`SBM_IW-1:0] gidx
);
    reg [`SBM_IW-1:0] owner;
    reg owner_valid;
    // Set only while the owner is inside a burst; parking alone never
    // blocks another requester, so round robin keeps rotating.
    reg burst_own;
    reg [`SBM_IW-1:0] last;
    reg [`SBM_SLOT_W-1:0] slot_cnt;
    reg [NM-1:0] others;
    reg [NM-1:0] cand;
    reg expired;
    reg hold;
    reg found;
    reg [`SBM_IW-1:0] pick;
    integer k;
    integer idx;

    always @*
    begin
        others = req;
        others[owner] = 1'b0;
        expired = (slot_limit != {`SBM_SLOT_W{1'b0}}) && owner_valid &&
                  (slot_cnt >= slot_limit);
        hold = burst_own && req[owner] && !(expired && (|others));
        cand = (expired && (|others)) ? others : req;
        found = 1'b0;
        pick = {`SBM_IW{1'b0}};
        idx = 0;
        for (k = 1; k <= NM; k = k + 1)
        begin
            if (mode == `SBM_ARB_FIXED)
                idx = NM - k;
            else
                idx = (last + k) % NM;
            if (cand[idx] && (mode != `SBM_ARB_FIXED || 1'b1))
            begin
                if (mode == `SBM_ARB_FIXED || !found)
                    pick = idx[`SBM_IW-1:0];
                found = 1'b1;
            end
        end
        gnt = {NM{1'b0}};
        gidx = hold ? owner : pick;
        if (hold || found)
            gnt[gidx] = 1'b1;
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            owner <= {`SBM_IW{1'b0}};
            owner_valid <= 1'b0;
            burst_own <= 1'b0;
            last <= {`SBM_IW{1'b0}};
            slot_cnt <= {`SBM_SLOT_W{1'b0}};
        end
        else if (ce)
        begin
            if (beat_done)
            begin
                last <= gidx;
                burst_own <= burst_more[gidx];
                if (owner_valid && gidx == owner && (&slot_cnt) == 1'b0)
                    slot_cnt <= slot_cnt + 1'b1;
                else if (!(owner_valid && gidx == owner))
                    slot_cnt <= {{(`SBM_SLOT_W-1){1'b0}}, 1'b1};
                if (burst_more[gidx])
                begin
                    owner <= gidx;
                    owner_valid <= 1'b1;
                end
                else
                begin
                    owner <= (mode == `SBM_ARB_RR_FIXED) ? default_master : gidx;
                    owner_valid <= (mode == `SBM_ARB_RR_LAST) ||
                                   (mode == `SBM_ARB_RR_FIXED);
                    slot_cnt <= {`SBM_SLOT_W{1'b0}};
                end
            end
            else if (!(|req))
            begin
                // Park the bus on the default master while idle, in SBM_ARB_RR_FIXED mode only
                slot_cnt <= {`SBM_SLOT_W{1'b0}};
                burst_own <= 1'b0;
                if (mode == `SBM_ARB_RR_FIXED)
                begin
                    owner <= default_master;
                    owner_valid <= 1'b1;
                end
                else if (mode != `SBM_ARB_RR_LAST)
                    owner_valid <= 1'b0;
            end
        end
    end
endmodule // sbm_arbiter

// [sbm_matrix.v]
// Six-layer bus matrix: decoders, slave arbiters, routing and boot control
`timescale 1ns/10ps
`include "sbm_map.vh"
module sbm_matrix
#(
    parameter NM = 6,
    parameter NS = 5
)
(
    input wire mclk,
    input wire reset_n,
    input wire ce,
    input wire boot_select_pin,
    input wire remap_set,
    input wire remap_clear,
    output reg remap,
    output reg boot_select,
    input wire cfg_wr,
    input wire cfg_voltage,
    input wire cfg_slew,
    output reg extbus_voltage_select,
    output reg extbus_slew_select,
    input wire [NS*2-1:0] arb_mode,
    input wire [NS*`SBM_IW-1:0] arb_default_master,
    input wire [NS*`SBM_SLOT_W-1:0] arb_slot_limit,
    input wire [NM-1:0] m_req,
    input wire [NM*`SBM_AW-1:0] m_addr,
    input wire [NM-1:0] m_write,
    input wire [NM*`SBM_DW-1:0] m_wdata,
    input wire [NM-1:0] m_burst,
    output reg [NM-1:0] m_ready,
    output reg [NM-1:0] m_rvalid,
    output reg [NM*`SBM_DW-1:0] m_rdata,
    output reg [NM-1:0] m_err,
    output reg [NS-1:0] s_req,
    output reg [NS*`SBM_AW-1:0] s_addr,
    output reg [NS-1:0] s_write,
    output reg [NS*`SBM_DW-1:0] s_wdata,
    output reg [NS*`SBM_IW-1:0] s_master,
    input wire [NS-1:0] s_ready,
    input wire [NS*`SBM_DW-1:0] s_rdata,
    input wire [NS-1:0] s_err
);
    // ******************************************************************
    // Internal nets
    // ******************************************************************
    wire [NM*NS-1:0] tgt;
    wire [NM-1:0] derr;
    wire [NS*NM-1:0] gnt;
    wire [NS*`SBM_IW-1:0] gidx;
    reg [NS*NM-1:0] slave_req;
    reg [NM-1:0] next_done;
    reg [NM-1:0] next_err;
    reg [NM*`SBM_DW-1:0] next_rdata;
    reg boot_taken;
    integer i;
    integer j;
    integer ri;
    integer rj;
    integer ai;
    integer aj;

    // ******************************************************************
    // Boot select, remap and external bus configuration
    // ******************************************************************
    // The pin is taken on the first enabled edge after reset release,
    // so the async reset branch only ever loads constants.
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            boot_taken <= 1'b0;
            boot_select <= `SBM_BOOT_EXT;
            remap <= 1'b0;
            extbus_voltage_select <= `SBM_VSEL_3V3;
            extbus_slew_select <= `SBM_SLEW_FAST;
        end
        else if (ce)
        begin
            if (!boot_taken)
            begin
                boot_select <= boot_select_pin;
                boot_taken <= 1'b1;
            end
            if (remap_set)
                remap <= 1'b1;
            else if (remap_clear)
                remap <= 1'b0;
            if (cfg_wr)
            begin
                extbus_voltage_select <= cfg_voltage;
                extbus_slew_select <= cfg_slew;
            end
        end
    end

    // ******************************************************************
    // Master layers: one decoder each
    // ******************************************************************
    genvar gm;
    generate
        for (gm = 0; gm < NM; gm = gm + 1)
        begin : g_layer
            // Identical map everywhere; only the wired paths differ
            sbm_decoder
            #(
                .ACCESS((gm < `SBM_FULL_MASTERS) ? `SBM_ACC_CPU :
                        `SBM_ACC_DMA)
            )
            u_dec
            (
                .addr(m_addr[gm*`SBM_AW +: `SBM_AW]),
                .remap(remap),
                .boot_select(boot_select),
                .target(tgt[gm*NS +: NS]),
                .err(derr[gm])
            );
        end
    endgenerate

    // ******************************************************************
    // Slave ports: one arbiter each
    // ******************************************************************
    always @*
    begin
        slave_req = {NS*NM{1'b0}};
        for (j = 0; j < NS; j = j + 1)
            for (i = 0; i < NM; i = i + 1)
                slave_req[j*NM+i] = m_req[i] & tgt[i*NS+j];
    end

    genvar gs;
    generate
        for (gs = 0; gs < NS; gs = gs + 1)
        begin : g_port
            sbm_arbiter
            #(
                .NM(NM)
            )
            u_arb
            (
                .mclk(mclk),
                .reset_n(reset_n),
                .ce(ce),
                .mode(arb_mode[gs*2 +: 2]),
                .default_master(arb_default_master[gs*`SBM_IW +: `SBM_IW]),
                .slot_limit(arb_slot_limit[gs*`SBM_SLOT_W +: `SBM_SLOT_W]),
                .req(slave_req[gs*NM +: NM]),
                .burst_more(m_burst),
                .beat_done(s_req[gs] & s_ready[gs]),
                .gnt(gnt[gs*NM +: NM]),
                .gidx(gidx[gs*`SBM_IW +: `SBM_IW])
            );
        end
    endgenerate

    // ******************************************************************
    // Routing toward the slaves
    // ******************************************************************
    // Address phase is muxed straight through so a slave can accept in
    // the same cycle as the grant; the cost is a longer combinational path.
    always @*
    begin
        s_req = {NS{1'b0}};
        s_addr = {NS*`SBM_AW{1'b0}};
        s_write = {NS{1'b0}};
        s_wdata = {NS*`SBM_DW{1'b0}};
        s_master = gidx;
        for (rj = 0; rj < NS; rj = rj + 1)
            for (ri = 0; ri < NM; ri = ri + 1)
                if (gnt[rj*NM+ri])
                begin
                    s_req[rj] = ce & slave_req[rj*NM+ri];
                    s_addr[rj*`SBM_AW +: `SBM_AW] =
                        m_addr[ri*`SBM_AW +: `SBM_AW];
                    s_write[rj] = m_write[ri];
                    s_wdata[rj*`SBM_DW +: `SBM_DW] =
                        m_wdata[ri*`SBM_DW +: `SBM_DW];
                end
    end

    // ******************************************************************
    // Answers toward the masters
    // ******************************************************************
    // A refused path completes locally with an error and never
    // appears at any slave port.
    always @*
    begin
        m_ready = {NM{1'b0}};
        next_done = {NM{1'b0}};
        next_err = {NM{1'b0}};
        next_rdata = {NM*`SBM_DW{1'b0}};
        for (ai = 0; ai < NM; ai = ai + 1)
        begin
            if (ce && m_req[ai] && derr[ai])
            begin
                m_ready[ai] = 1'b1;
                next_err[ai] = 1'b1;
            end
            for (aj = 0; aj < NS; aj = aj + 1)
                if (ce && slave_req[aj*NM+ai] && gnt[aj*NM+ai] &&
                    s_ready[aj])
                begin
                    m_ready[ai] = 1'b1;
                    next_err[ai] = s_err[aj];
                    next_rdata[ai*`SBM_DW +: `SBM_DW] =
                        s_rdata[aj*`SBM_DW +: `SBM_DW];
                end
            next_done[ai] = m_ready[ai];
        end
    end

    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            m_rvalid <= {NM{1'b0}};
            m_err <= {NM{1'b0}};
            m_rdata <= {NM*`SBM_DW{1'b0}};
        end
        else if (ce)
        begin
            m_rvalid <= next_done;
            m_err <= next_err;
            m_rdata <= next_rdata;
        end
    end
endmodule // sbm_matrix

// [sbm_matrix_sva.sv]
// Port-level assertions for the six-layer bus matrix
`timescale 1ns/10ps
`include "sbm_map.vh"
module sbm_matrix_sva
#(
    parameter NM = 6,
    parameter NS = 5
)
(
    input wire mclk,
    input wire reset_n,
    input wire ce,
    input wire boot_select_pin,
    input wire remap_set,
    input wire remap_clear,
    input wire remap,
    input wire boot_select,
    input wire cfg_wr,
    input wire cfg_voltage,
    input wire cfg_slew,
    input wire extbus_voltage_select,
    input wire extbus_slew_select,
    input wire [NM-1:0] m_req,
    input wire [NM*`SBM_AW-1:0] m_addr,
    input wire [NM-1:0] m_ready,
    input wire [NM-1:0] m_rvalid,
    input wire [NM-1:0] m_err,
    input wire [NS-1:0] s_req,
    input wire [NS*`SBM_IW-1:0] s_master
);
// ****************************************
// Helper logic
// ****************************************
wire [NM-1:0] taken = m_req & m_ready;
reg strap_taken;
always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
        strap_taken <= 1'b0;
    else if (ce)
        strap_taken <= 1'b1;
end
default clocking cb @(posedge mclk);
endclocking
default disable iff (!reset_n);
a_beat_answer:
    assert property ($past(ce) |-> m_rvalid == $past(taken))
    else $error("answer pulse does not follow accepted beat");
a_rom_path:
    assert property (s_req[2] |-> s_master[8:6] < 3'h3)
    else $error("rom port granted to a dma-only master");
a_periph_path:
    assert property (s_req[4] |-> s_master[14:12] < 3'h3)
    else $error("peripheral port granted to a dma-only master");
a_strap_capture:
    assert property (!strap_taken && ce |=> boot_select == $past(boot_select_pin))
    else $error("boot level not captured");
a_strap_hold:
    assert property (strap_taken |=> $stable(boot_select))
    else $error("boot level changed after capture");
a_cfg_load:
    assert property (cfg_wr && ce |=> extbus_voltage_select == $past(cfg_voltage)
        && extbus_slew_select == $past(cfg_slew))
    else $error("config bits not loaded");
a_remap_cmd:
    assert property (ce && (remap_set || remap_clear) |=> remap == $past(remap_set))
    else $error("remap command ignored");
a_unused_abort:
    assert property (ce && m_req[0] && m_addr[31:28] inside {[4'h8:4'hE]}
        |-> m_ready[0] ##1 (m_err[0] && m_rvalid[0]))
    else $error("unused region not aborted");
endmodule // sbm_matrix_sva

bind sbm_matrix sbm_matrix_sva #(.NM(NM), .NS(NS)) sbm_matrix_sva_inst (.mclk,
    .reset_n, .ce, .boot_select_pin, .remap_set, .remap_clear, .remap,
    .boot_select, .cfg_wr, .cfg_voltage, .cfg_slew, .extbus_voltage_select,
    .extbus_slew_select, .m_req, .m_addr, .m_ready, .m_rvalid, .m_err, .s_req,
    .s_master);

// [sbm_slave_model.sv]
// Behavioural model of the five slave ports facing the matrix
`timescale 1ns/10ps
`include "sbm_map.vh"
module sbm_slave_model
#(
    parameter NS = 5
)
(
    input wire mclk,
    input wire reset_n,
    input wire slow,
    input wire [NS-1:0] s_req,
    input wire [NS*`SBM_AW-1:0] s_addr,
    output logic [NS-1:0] s_ready,
    output logic [NS*`SBM_DW-1:0] s_rdata,
    output logic [NS-1:0] s_err
);
// ****************************************
// Slave answers
// ****************************************
logic tog;
always @(posedge mclk or negedge reset_n)
begin
    if (!reset_n)
        tog <= 1'b0;
    else
        tog <= ~tog;
end
// Idle ports flip every cycle so stale data never passes for an answer
always @*
begin
    for (int j = 0; j < NS; j++)
    begin
        s_ready[j] = s_req[j] & (~slow | tog);
        s_rdata[j*32+:32] = s_req[j] ? s_addr[j*32+:32] + 32'(j + 1) : {32{tog}};
        s_err[j] = s_req[j] & (s_addr[j*32+:8] == 8'hEE);
    end
end
endmodule // sbm_slave_model

// [sbm_matrix_tb.sv]
// Self-checking testbench of the six-layer bus matrix
`timescale 1ns/10ps
`include "sbm_map.vh"
module sbm_matrix_tb;
// ****************************************
// Stimulus and checks
// ****************************************
logic mclk = 1'b0, reset_n = 1'b0, ce = 1'b1, slow = 1'b0;
logic boot_select_pin = 1'b1, remap_set = 1'b0, remap_clear = 1'b0;
logic cfg_wr = 1'b0, cfg_voltage = 1'b0, cfg_slew = 1'b0;
logic remap, boot_select, extbus_voltage_select, extbus_slew_select;
logic [9:0] arb_mode = 10'h2D8;
logic [5:0] m_req = 6'h00, m_burst = 6'h00, m_ready, m_rvalid, m_err;
logic [39:0] slot = 40'h0;
logic [191:0] m_addr = 192'h0, m_rdata;
logic [4:0] s_req, s_ready, s_err, s_write;
logic [159:0] s_addr, s_rdata, s_wdata;
logic [14:0] s_master;
int err_total = 0, n_compared = 0;
always #2 mclk = ~mclk;
sbm_matrix sbm_matrix_inst (.mclk, .reset_n, .ce, .boot_select_pin, .remap_set,
    .remap_clear, .remap, .boot_select, .cfg_wr, .cfg_voltage, .cfg_slew,
    .extbus_voltage_select, .extbus_slew_select, .arb_mode,
    .arb_default_master(15'h4C1), .arb_slot_limit(slot), .m_req, .m_addr,
    .m_write(6'h15), .m_wdata(m_addr), .m_burst, .m_ready, .m_rvalid,
    .m_rdata, .m_err, .s_req, .s_addr, .s_write, .s_wdata, .s_master,
    .s_ready, .s_rdata, .s_err);
sbm_slave_model sbm_slave_model_inst (.mclk, .reset_n, .slow, .s_req, .s_addr,
    .s_ready, .s_rdata, .s_err);
task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
        err_total++;
        $display("Error %s expected %h seen %h", what, exp, seen);
    end
endtask
task summarize;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
// One beat from master m; sl is the slave expected to answer
task beat(input int m, input logic [31:0] a, input int sl, input logic e);
    int n;
    @(posedge mclk);
    m_req[m] <= 1'b1;
    m_addr[m*32+:32] <= a;
    #1;
    n = 0;
    while (m_ready[m] !== 1'b1 && n < 40)
    begin
        @(posedge mclk);
        #1;
        n++;
    end
    @(posedge mclk);
    m_req[m] <= 1'b0;
    #1;
    chk("rvalid", m_rvalid[m], 1'b1);
    chk("err", m_err[m], e);
    if (!e)
        chk("rdata", m_rdata[m*32+:32], a + 32'(sl + 1));
endtask
task remap_pulse(input logic s, input logic c);
    @(posedge mclk);
    remap_set <= s;
    remap_clear <= c;
    @(posedge mclk);
    remap_set <= 1'b0;
    remap_clear <= 1'b0;
    #1;
    chk("remap", remap, s);
endtask
task t_boot;
    chk("vsel", extbus_voltage_select, `SBM_VSEL_3V3);
    chk("slew", extbus_slew_select, `SBM_SLEW_FAST);
    chk("boot", boot_select, `SBM_BOOT_ROM);
    beat(0, 32'h0000_0010, 2, 1'b0);
    remap_pulse(1'b1, 1'b1);
    beat(1, 32'h0000_0020, 0, 1'b0);
    remap_pulse(1'b0, 1'b1);
endtask
task t_map;
    logic [31:0] ad [0:9];
    int sl [0:9];
    ad = '{32'h0010_0000, 32'h0020_0000, 32'h0030_0000, 32'h0050_0000,
        32'h1000_0000, 32'h7FF0_0000, 32'hF000_0000, 32'h8000_0000,
        32'hE000_0000, 32'h0040_0000};
    sl = '{2, 0, 1, 2, 3, 3, 4, -1, -1, -1};
    for (int i = 0; i < 10; i++)
        beat(0, ad[i], sl[i], sl[i] < 0);
endtask
task t_matrix;
    @(posedge mclk);
    slow <= 1'b1;
    for (int m = 2; m < 6; m++)
    begin
        beat(m, 32'h0020_0004, 0, 1'b0);
        beat(m, 32'h1000_0004, 3, 1'b0);
        beat(m, 32'h0010_0004, 2, m > 2);
        beat(m, 32'hF000_0004, 4, m > 2);
    end
    beat(1, 32'h0030_00EE, 1, 1'b1);
    @(posedge mclk);
    slow <= 1'b0;
endtask
task t_parallel;
    @(posedge mclk);
    m_req <= 6'h11;
    m_addr[31:0] <= 32'h0020_0000;
    m_addr[159:128] <= 32'h1000_0000;
    #1;
    chk("both ready", m_ready[0] & m_ready[4], 1'b1);
    chk("write0", s_write[0], 1'b1);
    chk("wdata0", s_wdata[31:0], 32'h0020_0000);
    chk("write3", s_write[3], 1'b1);
    chk("wdata3", s_wdata[127:96], 32'h1000_0000);
    @(posedge mclk);
    m_req <= 6'h00;
endtask
// Burst owner keeps the port until the slot limit of two beats runs out
task t_burst;
    @(posedge mclk);
    arb_mode[1:0] <= `SBM_ARB_RR_NONE;
    slot[7:0] <= 8'h02;
    m_req <= 6'h02;
    m_burst <= 6'h02;
    @(posedge mclk);
    m_req <= 6'h0A;
    #1;
    chk("burst hold", s_master[2:0], 3'h1);
    @(posedge mclk);
    #1;
    chk("slot break", s_master[2:0], 3'h3);
    @(posedge mclk);
    m_req <= 6'h00;
    m_burst <= 6'h00;
    slot <= 40'h0;
endtask
task t_arb;
    logic [2:0] g0;
    for (int md = 0; md < 4; md++)
    begin
        @(posedge mclk);
        arb_mode[1:0] <= md[1:0];
        m_req <= 6'h0A;
        m_addr[63:32] <= 32'h0020_0000;
        m_addr[127:96] <= 32'h0020_0100;
        #1;
        g0 = s_master[2:0];
        if (md == 0)
            chk("fixed winner", g0, 3'h1);
        @(posedge mclk);
        #1;
        chk("rotation", s_master[2:0] == g0, md == 0);
        @(posedge mclk);
        m_req <= 6'h00;
    end
endtask
task t_cfg;
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_voltage <= 1'b1;
    cfg_slew <= 1'b1;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    #1;
    chk("vsel", extbus_voltage_select, `SBM_VSEL_1V8);
    chk("slew", extbus_slew_select, `SBM_SLEW_SLOW);
endtask
task t_strap0;
    @(posedge mclk);
    reset_n <= 1'b0;
    boot_select_pin <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("boot", boot_select, `SBM_BOOT_EXT);
    chk("vsel", extbus_voltage_select, `SBM_VSEL_3V3);
    beat(1, 32'h0000_0040, 3, 1'b0);
    remap_pulse(1'b1, 1'b0);
    beat(1, 32'h0000_0040, 0, 1'b0);
endtask
initial
begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    t_boot;
    t_map;
    t_matrix;
    t_parallel;
    t_arb;
    t_burst;
    t_cfg;
    t_strap0;
    summarize;
end
initial
begin
    #40000;
    err_total++;
    summarize;
end
endmodule // sbm_matrix_tb
